//--- core/acs_scaler.sv
/*
 * Holds the analog channel scaler: conversion sequencer, input scaling, image words, output code map
 * and Avalon-MM register slave.
 * Assumes a converter that returns a signed 16-bit code spanning its full input range (10.5 V on
 * channels 0 and 1, 21 mA on channels 2 and 3), and a 16-bit output converter spanning 10 V or 24 mA.
 */
// What this block does
// [RULE1] Filter selectable 10/50/60/250 Hz, settle and resolution.
// [RULE2] Filter defaults to 60 Hz after reset.
// [RULE3] Channel refresh is conversion time plus settling.
// [RULE4] Several channels: scan plus update plus settling.
// [RULE5] One channel: update plus scan, no settling.
// [RULE6] Results are 16-bit two's complement words.
// [RULE7] Current inputs scale to 32767 at 21 mA.
// [RULE8] Voltage inputs scale to 32767 at 10.5 V.
// [RULE9] Current output is 4 mA plus N*16/32767.
// [RULE10] Voltage output is N*10/32767 volts.
// [RULE11] Input words 4-7 cleared at run entry.
// [RULE12] Channels individually enabled, all enabled by default.
// [RULE13] Output drives its configured terminal only in run.
// [RULE14] Visit enabled channels ascending, wrap to lowest.
// [RULE15] Image words update atomically for the scan; the code writes each word on its own as its result leaves the FIFO.
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_scaler
   import acs_pkg::*;
#(
   parameter int SETTLE_10_CYC = `ACS_SETTLE_10HZ_US * `ACS_CLK_MHZ,
   parameter int SETTLE_50_CYC = `ACS_SETTLE_50HZ_US * `ACS_CLK_MHZ,
   parameter int SETTLE_60_CYC = `ACS_SETTLE_60HZ_US * `ACS_CLK_MHZ,
   parameter int SETTLE_250_CYC = `ACS_SETTLE_250HZ_US * `ACS_CLK_MHZ
)
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic [1:0] o_adc_mux,
   output logic [1:0] o_filt_sel,
   output logic o_adc_start,
   input wire logic i_adc_done,
   input wire logic [15:0] i_adc_data,
   output logic [15:0] o_dac_code,
   output logic o_vout_en,
   output logic o_iout_en
);
   // ******************************************************************
   // Declarations.
   // ******************************************************************
   acs_stream_if #(.W(18)) res_in ();
   acs_stream_if #(.W(18)) res_out ();

   logic ack;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic run;
   logic run_q;
   acs_filt_t filt;
   logic [3:0] ch_en;
   logic omode;
   logic [15:0] out_word;
   logic [15:0] img [4];
   logic next_run;
   acs_filt_t next_filt;
   logic [3:0] next_ch_en;
   logic next_omode;
   logic [15:0] next_out_word;
   logic [15:0] next_img [4];
   logic [31:0] wmask;
   logic [31:0] ctrl_word;
   logic wr_hit;
   logic enter_run_transition;
   logic done_s1;
   logic done_s2;
   logic done_q;
   logic [15:0] data_s1;
   logic [15:0] data_s2;
   acs_seq_t state;
   acs_seq_t next_state;
   logic [1:0] ch;
   logic [1:0] next_ch;
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic [15:0] word;
   logic [15:0] next_word;
   logic start;
   logic next_start;
   logic single;
   logic [31:0] settle_cyc;
   logic signed [31:0] prod;
   logic [16:0] dac_calc;
   logic [15:0] nn;

   // ******************************************************************
   // Avalon-MM slave: one wait cycle, then the answer for one cycle.
   // ******************************************************************
   assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                   {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
   assign ctrl_word = {23'h0, omode, ch_en, 1'b0, filt, run};
   assign wr_hit = i_avs_write & ack;

   // Read data is captured whole in one edge, so an image word never reads half updated.
   always_comb
   begin
      next_rdata = 32'h0;
      unique case (i_avs_address)
         `ACS_OFS_CTRL: next_rdata = ctrl_word;
         `ACS_OFS_STAT: next_rdata = {26'h0, ~res_in.ready, run, state, ch};
         `ACS_OFS_OUT: next_rdata = {16'h0, out_word};
         default:
         begin
            if (i_avs_address[4] && i_avs_address[1:0] == 2'h0)
            begin
               next_rdata = {16'h0, img[i_avs_address[3:2]]}; // [RULE15]
            end
         end
      endcase
   end

   // Acknowledge register drives waitrequest low for exactly one cycle per request.
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         ack <= 1'b0;
         rdata <= 32'h0;
         o_avs_waitrequest <= 1'b1;
      end
      else
      begin
         ack <= (i_avs_read | i_avs_write) & ~ack;
         rdata <= next_rdata;
         o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & ~ack);
      end
   end
   assign o_avs_readdata = rdata;

   // ******************************************************************
   // Configuration and image words.
   // ******************************************************************
   assign enter_run_transition = run & ~run_q;

   // Next configuration values and image updates from the result FIFO.
   always_comb
   begin
      logic [31:0] merged;
      merged = (ctrl_word & ~wmask) | (i_avs_writedata & wmask);
      next_run = run;
      next_filt = filt;
      next_ch_en = ch_en;
      next_omode = omode;
      next_out_word = out_word;
      next_img = img;
      if (wr_hit && i_avs_address == `ACS_OFS_CTRL)
      begin
         next_run = merged[`ACS_CTRL_RUN];
         next_filt = acs_filt_t'(merged[`ACS_CTRL_FILT_HI:`ACS_CTRL_FILT_LO]); // [RULE1]
         next_ch_en = merged[`ACS_CTRL_EN_HI:`ACS_CTRL_EN_LO]; // [RULE12]
         next_omode = merged[`ACS_CTRL_OMODE];
      end
      if (wr_hit && i_avs_address == `ACS_OFS_OUT)
      begin
         next_out_word = (out_word & ~wmask[15:0]) | (i_avs_writedata[15:0] & wmask[15:0]);
      end
      if (enter_run_transition)
      begin
         next_img = '{default: 16'h0}; // [RULE11]
      end
      else if (res_out.valid && res_out.ready)
      begin
         next_img[res_out.data[17:16]] = res_out.data[15:0]; // [RULE11] [RULE15]
      end
   end

   // Configuration registers.
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         run <= 1'b0;
         run_q <= 1'b0;
         filt <= acs_filt_t'(`ACS_RST_FILT); // [RULE2]
         ch_en <= `ACS_RST_EN; // [RULE12]
         omode <= `ACS_RST_OMODE;
         out_word <= 16'h0;
         img <= '{default: 16'h0};
      end
      else
      begin
         run <= next_run;
         run_q <= run;
         filt <= next_filt;
         ch_en <= next_ch_en;
         omode <= next_omode;
         out_word <= next_out_word;
         img <= next_img;
      end
   end

   // Image writes pause in the wait cycle of a read; the FIFO absorbs the burst.
   assign res_out.ready = ~(i_avs_read & ~ack);

   acs_fifo #(.W(18), .DEPTH(`ACS_FIFO_DEPTH)) u_fifo
   (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_clear(enter_run_transition),
      .s_in(res_in),
      .s_out(res_out)
   );

   // ******************************************************************
   // Converter handshake synchronisers.
   // ******************************************************************
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         done_s1 <= 1'b0;
         done_s2 <= 1'b0;
         done_q <= 1'b0;
         data_s1 <= 16'h0;
         data_s2 <= 16'h0;
      end
      else
      begin
         done_s1 <= i_adc_done;
         done_s2 <= done_s1;
         done_q <= done_s2;
         data_s1 <= i_adc_data;
         data_s2 <= data_s1;
      end
   end

   // ******************************************************************
   // Conversion sequencer.
   // ******************************************************************
   // Next enabled channel above the current one, wrapping to the lowest.
   function automatic logic [1:0] acs_next_ch(input logic [1:0] cur, input logic [3:0] en);
      logic [1:0] c;
      acs_next_ch = cur;
      for (int k = 4; k >= 1; k--)
      begin
         c = cur + k[1:0];
         if (en[c])
         begin
            acs_next_ch = c; // [RULE14]
         end
      end
   endfunction

   assign single = (ch_en == 4'h1) || (ch_en == 4'h2) || (ch_en == 4'h4) || (ch_en == 4'h8);

   // Settling count of the chosen filter.
   always_comb
   begin
      unique case (filt)
         ACS_F10: settle_cyc = SETTLE_10_CYC; // [RULE1]
         ACS_F50: settle_cyc = SETTLE_50_CYC;
         ACS_F60: settle_cyc = SETTLE_60_CYC;
         ACS_F250: settle_cyc = SETTLE_250_CYC;
      endcase
   end

   // Scaling: converter code times 32767 over 32768 gives the image word for either unit.
   assign prod = $signed(data_s2) * `ACS_FULL_WORD;

   // Next sequencer values.
   always_comb
   begin
      next_state = state;
      next_ch = ch;
      next_cnt = cnt;
      next_word = word;
      next_start = 1'b0;
      res_in.valid = 1'b0;
      res_in.data = {ch, word};
      unique case (state)
         ACS_IDLE:
         begin
            if (run && ch_en != 4'h0)
            begin
               next_ch = acs_next_ch(ch, ch_en); // [RULE14]
               next_cnt = single ? 32'h0 : settle_cyc; // [RULE3] [RULE4] [RULE5]
               next_state = ACS_SETTLE;
            end
         end
         ACS_SETTLE:
         begin
            if (cnt != 32'h0)
            begin
               next_cnt = cnt - 32'h1;
            end
            else
            begin
               next_start = 1'b1;
               next_state = ACS_CONV;
            end
         end
         ACS_CONV:
         begin
            if (done_s2 && !done_q)
            begin
               next_word = prod[30:15]; // [RULE6] [RULE7] [RULE8]
               if (filt == ACS_F250)
               begin
                  next_word = {prod[30:16], 1'b0}; // [RULE1]
               end
               next_state = ACS_PUSH;
            end
         end
         ACS_PUSH:
         begin
            res_in.valid = 1'b1;
            if (res_in.ready)
            begin
               next_state = ACS_IDLE;
            end
         end
      endcase
      if (!run)
      begin
         next_state = ACS_IDLE;
         next_start = 1'b0; // No conversion is launched once run has dropped.
      end
   end

   // Sequencer registers.
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         state <= ACS_IDLE;
         ch <= 2'h3;
         cnt <= 32'h0;
         word <= 16'h0;
         start <= 1'b0;
      end
      else
      begin
         state <= next_state;
         ch <= next_ch;
         cnt <= next_cnt;
         word <= next_word;
         start <= next_start;
      end
   end
   assign o_adc_start = start;
   assign o_adc_mux = ch;
   assign o_filt_sel = filt;

   // ******************************************************************
   // Analog output code map.
   // ******************************************************************
   assign nn = out_word[15] ? 16'h0 : out_word;

   // Voltage doubles the word, so 32767 gives code 65534; current adds the 4 mA base.
   always_comb
   begin
      logic [32:0] t;
      t = 33'h0;
      if (omode)
      begin
         t = {17'h0, nn} * {16'h0, `ACS_IOUT_GAIN};
         dac_calc = `ACS_IOUT_BASE + t[31:15]; // [RULE9]
      end
      else
      begin
         dac_calc = {nn, 1'b0}; // [RULE10]
      end
      if (dac_calc > `ACS_DAC_MAX)
      begin
         dac_calc = `ACS_DAC_MAX;
      end
   end

   // Output registers enable only the configured terminal and only in run.
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_dac_code <= 16'h0;
         o_vout_en <= 1'b0;
         o_iout_en <= 1'b0;
      end
      else
      begin
         o_dac_code <= run ? dac_calc[15:0] : 16'h0;
         o_vout_en <= run & ~omode; // [RULE13]
         o_iout_en <= run & omode; // [RULE13]
      end
   end
endmodule // acs_scaler

//--- core/acs_consts.svh
/*
 * Holds the offsets, field positions, reset values, scaling figures and timing counts of the analog
 * channel scaler. Assumes it is included by its bare name after any timescale directive.
 */
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// ******************************************************************
// Register byte offsets on the Avalon-MM slave.
// ******************************************************************
`define ACS_OFS_CTRL 5'h00
`define ACS_OFS_STAT 5'h04
`define ACS_OFS_OUT 5'h08
`define ACS_OFS_IN0 5'h10
`define ACS_OFS_IN3 5'h1c

// ******************************************************************
// Control register fields and reset values.
// ******************************************************************
`define ACS_CTRL_RUN 0
`define ACS_CTRL_FILT_LO 1
`define ACS_CTRL_FILT_HI 2
`define ACS_CTRL_EN_LO 4
`define ACS_CTRL_EN_HI 7
`define ACS_CTRL_OMODE 8
`define ACS_RST_FILT 2'h2
`define ACS_RST_EN 4'hf
`define ACS_RST_OMODE 1'h0

// ******************************************************************
// Clock rate and filter settling times in microseconds.
// ******************************************************************
`define ACS_CLK_MHZ 125
`define ACS_SETTLE_10HZ_US 100000
`define ACS_SETTLE_50HZ_US 20000
`define ACS_SETTLE_60HZ_US 16670
`define ACS_SETTLE_250HZ_US 16000

// ******************************************************************
// Scaling figures: full-scale word, the analog output code map and the result FIFO depth.
// ******************************************************************
`define ACS_FULL_WORD 32767
`define ACS_IN_SHIFT 15
`define ACS_IOUT_BASE 17'h02aaa
`define ACS_IOUT_GAIN 17'h0aaab
`define ACS_DAC_MAX 17'h0ffff
`define ACS_FIFO_DEPTH 32

`endif

//--- core/acs_pkg.sv
/*
 * Holds the types shared by the analog channel scaler modules.
 * Assumes nothing of its surroundings.
 */
package acs_pkg;

   // Filter first-notch choices.
   typedef enum logic [1:0] {ACS_F10 = 2'h0, ACS_F50 = 2'h1, ACS_F60 = 2'h2, ACS_F250 = 2'h3} acs_filt_t;

   // Conversion sequencer states, Gray coded along the cycle.
   typedef enum logic [1:0] {ACS_IDLE = 2'h0, ACS_SETTLE = 2'h1, ACS_CONV = 2'h3, ACS_PUSH = 2'h2} acs_seq_t;

endpackage

//--- core/acs_stream_if.sv
/*
 * Holds the valid/ready stream carrier used between the scaler and its result FIFO.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface acs_stream_if #(parameter int W = 18) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

//--- core/acs_fifo.sv
/*
 * Holds a synchronous FIFO with valid and ready on both sides.
 * Assumes one clock and an active-low asynchronous reset; i_clear empties it in one cycle.
 */
`timescale 1ns/1ps
module acs_fifo
   import acs_pkg::*;
#(
   parameter int W = 18,
   parameter int DEPTH = 32
)
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_clear,
   acs_stream_if.snk s_in,
   acs_stream_if.src s_out
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic [AW:0] next_wr_ptr;
   logic [AW:0] next_rd_ptr;
   logic full;
   logic empty;
   logic do_wr;
   logic do_rd;

   // Full and empty come from pointers that carry one extra wrap bit.
   assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign empty = (wr_ptr == rd_ptr);
   assign s_in.ready = ~full;
   assign s_out.valid = ~empty;
   assign s_out.data = mem[rd_ptr[AW-1:0]];
   assign do_wr = s_in.valid & ~full;
   assign do_rd = s_out.ready & ~empty;

   // Next pointer values.
   always_comb
   begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      if (i_clear)
      begin
         next_rd_ptr = wr_ptr;
      end
      else
      begin
         if (do_wr)
         begin
            next_wr_ptr = wr_ptr + 1'b1;
         end
         if (do_rd)
         begin
            next_rd_ptr = rd_ptr + 1'b1;
         end
      end
   end

   // Pointer registers.
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   // Storage is written only on an accepted word.
   always_ff @(posedge i_clk)
   begin
      if (do_wr && !i_clear)
      begin
         mem[wr_ptr[AW-1:0]] <= s_in.data;
      end
   end
endmodule // acs_fifo

//--- sim/acs_scaler_assertions.sv
/* Holds the port checker of the analog channel scaler.
   Assumes it is bound to acs_scaler by the bind statement at its foot. */
`timescale 1ns/1ps
module acs_checker (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic [1:0] o_adc_mux,
   input wire logic [1:0] o_filt_sel,
   input wire logic o_adc_start,
   input wire logic i_adc_done,
   input wire logic [15:0] i_adc_data,
   input wire logic [15:0] o_dac_code,
   input wire logic o_vout_en,
   input wire logic o_iout_en
);
   // ******************************************************************
   // Bus, sequencer and output relations.
   // ******************************************************************
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // The slave answers one edge after a new request and only for one cycle.
   bus_answer_a: assert property ($rose(i_avs_read) || $rose(i_avs_write) |=> !o_avs_waitrequest)
      else $error("Bus request not answered in one cycle.");
   wait_short_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("Waitrequest low for more than one cycle.");
   unmapped_zero_a: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address == 5'h0c
      |-> o_avs_readdata == 32'h0) else $error("Unmapped read not zero.");
   image_word_a: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address[4]
      |-> o_avs_readdata[31:16] == 16'h0) else $error("Image word wider than 16 bits.");
   start_pulse_a: assert property (o_adc_start |=> !o_adc_start)
      else $error("Start pulse longer than one cycle.");
   mux_hold_a: assert property (o_adc_start |-> $stable(o_adc_mux))
      else $error("Channel changed at start.");
   filt_cause_a: assert property ($changed(o_filt_sel) |-> $past(i_avs_write) || $past(i_avs_write, 2))
      else $error("Filter changed without a write.");
   term_excl_a: assert property (!(o_vout_en && o_iout_en))
      else $error("Both output terminals enabled.");
   dac_idle_a: assert property (!o_vout_en && !o_iout_en |-> o_dac_code == 16'h0)
      else $error("Output code not zero while idle.");
   vout_even_a: assert property (o_vout_en |-> !o_dac_code[0])
      else $error("Voltage code odd.");
   iout_base_a: assert property (o_iout_en |-> o_dac_code >= 16'h2aaa)
      else $error("Current code below base.");
   // Main scenarios.
   start_c: cover property (o_adc_start);
   vout_c: cover property (o_vout_en && o_dac_code != 16'h0);
   iout_c: cover property (o_iout_en);
endmodule // acs_checker
bind acs_scaler acs_checker acs_checker_i (.i_clk, .i_rstn, .i_avs_address, .i_avs_read, .i_avs_write,
   .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_adc_mux, .o_filt_sel,
   .o_adc_start, .i_adc_done, .i_adc_data, .o_dac_code, .o_vout_en, .o_iout_en);

//--- sim/acs_adc_model.sv
/* Holds a behavioural input converter with one fixed code per channel.
   Assumes start and channel come from the scaler on the same clock. */
`timescale 1ns/1ps
module acs_adc_model #(
   parameter logic [63:0] CODES = 64'h0,
   parameter int LAT = 5
)
(
   input wire logic i_clk,
   input wire logic i_start,
   input wire logic [1:0] i_mux,
   output logic o_done,
   output logic [15:0] o_data
);
   int cnt = 0;
   logic [15:0] held = 16'h0;
   // Latches the selected channel's code at start, then counts down the conversion.
   always @(posedge i_clk)
   begin
      if (i_start)
      begin
         cnt <= LAT + 6;
         held <= CODES[i_mux*16 +: 16];
      end
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
   // Done stands six cycles; data is only valid meanwhile, else it shows the inverse.
   assign o_done = cnt > 0 && cnt <= 6;
   assign o_data = o_done ? held : ~held;
endmodule // acs_adc_model

//--- sim/acs_scaler_bench.sv
/* Holds the self-checking bench of the analog channel scaler.
   Assumes the design, its package and the converter model are compiled first. */
`timescale 1ns/1ps
module acs_scaler_bench;
   import acs_pkg::*;
   localparam logic [63:0] CODES = 64'h0100_7fff_c000_4000;
   localparam int ST[4] = '{20, 10, 8, 6};
   localparam logic [15:0] NV[4] = '{16'h0000, 16'h4000, 16'h7fff, 16'h8000};
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic [4:0] i_avs_address = 5'h0;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic i_adc_done;
   logic [15:0] i_adc_data;
   logic [31:0] o_avs_readdata, q;
   logic o_avs_waitrequest, o_adc_start, o_vout_en, o_iout_en;
   logic [1:0] o_adc_mux, o_filt_sel;
   logic [15:0] o_dac_code;
   logic [1:0] seen_mux[$];
   int num_errors = 0, cmp_count = 0, cyc = 0, starts = 0, gap = 0, last = 0, g1;

   acs_scaler #(.SETTLE_10_CYC(ST[0]), .SETTLE_50_CYC(ST[1]), .SETTLE_60_CYC(ST[2]), .SETTLE_250_CYC(ST[3]))
   acs_scaler_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
      .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hf),
      .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_adc_mux(o_adc_mux),
      .o_filt_sel(o_filt_sel), .o_adc_start(o_adc_start), .i_adc_done(i_adc_done), .i_adc_data(i_adc_data),
      .o_dac_code(o_dac_code), .o_vout_en(o_vout_en), .o_iout_en(o_iout_en));
   acs_adc_model #(.CODES(CODES), .LAT(5)) acs_adc_model_i (.i_clk(i_clk), .i_start(o_adc_start),
      .i_mux(o_adc_mux), .o_done(i_adc_done), .o_data(i_adc_data));

   // ******************************************************************
   // Clock, start monitor and helpers.
   // ******************************************************************
   // Makes the 125 MHz clock.
   initial forever #4 i_clk = ~i_clk;
   // Records the channel and spacing of every conversion start.
   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      if (o_adc_start === 1'b1)
      begin
         starts <= starts + 1;
         gap <= cyc - last;
         last <= cyc;
         seen_mux.push_back(o_adc_mux);
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Runs one Avalon access and holds it until waitrequest is sampled low.
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      i_avs_read <= !wr;
      i_avs_write <= wr;
      i_avs_address <= a;
      i_avs_writedata <= d;
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (o_avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) chk(32'h1, 32'h0);
      q = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
   endtask
   task automatic wait_starts(input int k);
      int t;
      t = 0;
      k += starts;
      while (starts < k && t < 5000)
      begin
         @(posedge i_clk);
         t++;
      end
      if (t >= 5000) chk(32'h1, 32'h0);
   endtask
   // Leaves run, lets a conversion in flight finish, then enters run again with the given control word.
   task automatic run(input logic [31:0] ctrl);
      bus(1'b1, 5'h00, ctrl & ~32'h1);
      repeat (16) @(posedge i_clk);
      seen_mux.delete();
      bus(1'b1, 5'h00, ctrl);
   endtask
   function automatic logic [15:0] exp_word(input logic [15:0] code, input logic f250);
      logic signed [31:0] p;
      p = ($signed({{16{code[15]}}, code}) * 32'sd32767) >>> 15;
      return f250 ? {p[15:1], 1'b0} : p[15:0];
   endfunction
   function automatic logic [15:0] exp_dac(input logic [15:0] n, input logic cur);
      logic [31:0] t;
      t = n[15] ? 32'h0 : {17'h0, n[14:0]};
      t = cur ? 32'h2aaa + ((t * 32'h0aaab) >> 15) : t << 1;
      return t > 32'hffff ? 16'hffff : t[15:0];
   endfunction
   task tally_and_finish;
      $display("Comparisons %0d, mismatches %0d.", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Cuts a hang short.
   initial
   begin
      #300000;
      num_errors++;
      tally_and_finish;
   end

   // ******************************************************************
   // Test sequence.
   // ******************************************************************
   initial
   begin
      repeat (5) @(posedge i_clk);
      i_rstn <= 1'b1;
      bus(1'b0, 5'h00, 32'h0);
      chk(q, 32'h0000_00f4);
      chk(o_filt_sel, 32'h2);
      for (int c = 0; c < 4; c++)
      begin
         bus(1'b0, 5'h10 + 5'(4*c), 32'h0);
         chk(q, 32'h0);
      end
      bus(1'b1, 5'h0c, 32'h1234);
      bus(1'b0, 5'h0c, 32'h0);
      chk(q, 32'h0);
      $display("Test reset and map done.");
      // Each filter: the settling count appears only with several channels.
      for (int f = 0; f < 4; f++)
      begin
         run(32'h11 | 32'(f << 1));
         wait_starts(3);
         g1 = gap;
         run(32'hf1 | 32'(f << 1));
         bus(1'b0, 5'h1c, 32'h0);
         chk(q, 32'h0);
         chk(o_filt_sel, 32'(f));
         wait_starts(5);
         chk(32'(gap - g1), 32'(ST[f]));
         for (int c = 0; c < 4; c++)
         begin
            chk(seen_mux[c], 32'((c + 1) % 4));
            bus(1'b0, 5'h10 + 5'(4*c), 32'h0);
            chk(q, exp_word(CODES[c*16 +: 16], f == 3));
         end
      end
      $display("Test filters and scaling done.");
      run(32'hb5);
      wait_starts(5);
      chk(32'(seen_mux[0] == 2'h2), 32'h0);
      for (int c = 0; c < 4; c++)
         chk(seen_mux[c + 1], 32'(seen_mux[c] == 2'h1 ? 2'h3 : 2'(seen_mux[c] + 2'h1)));
      bus(1'b0, 5'h18, 32'h0);
      chk(q, 32'h0);
      $display("Test channel order done.");
      for (int m = 0; m < 2; m++)
         for (int k = 0; k < 4; k++)
         begin
            bus(1'b1, 5'h08, {16'h0, NV[k]});
            bus(1'b1, 5'h00, 32'h5 | 32'(m << 8));
            repeat (3) @(posedge i_clk);
            chk({o_iout_en, o_vout_en}, m ? 32'h2 : 32'h1);
            chk(o_dac_code, exp_dac(NV[k], m[0]));
         end
      bus(1'b1, 5'h00, 32'h104);
      repeat (3) @(posedge i_clk);
      chk({o_iout_en, o_vout_en, o_dac_code}, 32'h0);
      $display("Test analog output done.");
      tally_and_finish;
   end
endmodule // acs_scaler_bench
